// *** lhp_regs.svh ***
// Offsets, reset values and timing counts for the host bus port
`ifndef LHP_REGS_SVH
`define LHP_REGS_SVH

`define LHP_PSAVE_ADDR      16'h0008
`define LHP_PSAVE_BIT       0
`define LHP_PSAVE_RST       1'b0

`define LHP_CLK_PERIOD_NS   10
`define LHP_WAIT_MAX_NS     42
`define LHP_WAIT_MAX_CYC    (`LHP_WAIT_MAX_NS / `LHP_CLK_PERIOD_NS)
`define LHP_NOWAIT_DATA_NS  58
`define LHP_NOWAIT_DATA_CYC (`LHP_NOWAIT_DATA_NS / `LHP_CLK_PERIOD_NS)
`define LHP_FLOAT_NS        10
`define LHP_FLOAT_CYC       (`LHP_FLOAT_NS / `LHP_CLK_PERIOD_NS)
`define LHP_ACK_DRIVE_NS    15
`define LHP_ACK_DRIVE_CYC   (`LHP_ACK_DRIVE_NS / `LHP_CLK_PERIOD_NS)
`define LHP_TAIL_CYC        1
`define LHP_TIMER_W         3

`endif

// *** lhp_pkg.sv ***
// Types shared by the host bus port modules
package lhp_pkg;
	typedef enum logic [1:0] {
		LHP_GEN_WAIT,
		LHP_GEN_NOWAIT,
		LHP_M68
	} lhp_mode_e;

	typedef enum logic [1:0] {
		LHP_IDLE,
		LHP_BUSY,
		LHP_DONE,
		LHP_TAIL
	} lhp_state_e;
endpackage

// *** lhp_wait_timer.sv ***
// Cycle counter bounding how long an access may hold the wait line
`timescale 1ns/1ps
`include "lhp_regs.svh"
module lhp_wait_timer (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic run,
	output logic      expired
);
	logic [`LHP_TIMER_W-1:0] cnt_q;
	logic [`LHP_TIMER_W-1:0] cnt_d;

	always_comb begin
		cnt_d = run ? cnt_q + `LHP_TIMER_W'(1) : '0;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// Last allowed cycle of the held wait
	assign expired = run && (cnt_q == `LHP_TIMER_W'(`LHP_WAIT_MAX_CYC - 1));
endmodule

// *** lhp_host_port.sv ***
// Host parallel bus port: strobes, wait/acknowledge line and core access
//
// Function
// - With wait in use, the port pulls wait low right after a strobe falls.
// - On the generic bus the port floats wait within 10 ns of the strobe rising.
// - Wait is never held active longer than four clocks plus 2 ns in one access.
// - With wait in use, read data is valid within one clock of wait being released.
// - Without wait, read data is valid within four clocks plus 18 ns of read falling.
// - On the strobed bus the port drives the acknowledge line within 15 ns of strobe fall.
// - On the strobed bus, direct and power save, wait floats within 10 ns of read rising.
// - On the strobed bus otherwise, wait deasserts within 10 ns of address strobe rising.
// - On the strobed bus, wait stays inactive from first drive at most four clocks plus 2 ns.
// - Power save is entered and left through bit 0 of register 08h.
`timescale 1ns/1ps
`include "lhp_regs.svh"
module lhp_host_port (
	input  wire logic        MCLK,
	input  wire logic        RST,
	input  wire logic [1:0]  BUS_MODE,
	input  wire logic        DIRECT_MODE,
	input  wire logic        CS_N,
	input  wire logic [15:0] HOST_ADDR,
	input  wire logic [7:0]  HOST_DATA_I,
	output logic      [7:0]  HOST_DATA_O,
	output logic             HOST_DATA_OE,
	input  wire logic        RD_N,
	input  wire logic        WR_N,
	input  wire logic        ADDR_STROBE_N,
	output logic             XFER_ACK_N_O,
	output logic             XFER_ACK_N_OE,
	output logic             CORE_REQ,
	output logic             CORE_WE,
	output logic      [15:0] CORE_ADDR,
	output logic      [7:0]  CORE_WDATA,
	input  wire logic        CORE_ACK,
	input  wire logic [7:0]  CORE_RDATA,
	output logic             POWER_SAVE
);
	lhp_pkg::lhp_mode_e  mode;
	lhp_pkg::lhp_state_e state_q;
	lhp_pkg::lhp_state_e state_d;
	logic        m68;
	logic        dstb_n;
	logic        dstb_prev_q;
	logic        as_prev_q;
	logic        start;
	logic        dstb_rise;
	logic        as_rise;
	logic        rd_rise;
	logic        rd_prev_q;
	logic        expired;
	logic        we_q;
	logic        we_d;
	logic        sent_q;
	logic        sent_d;
	logic        pend_q;
	logic        pend_d;
	logic        vld_q;
	logic        vld_d;
	logic        psave_q;
	logic        psave_d;
	logic [15:0] addr_q;
	logic [15:0] addr_d;
	logic [7:0]  wdata_q;
	logic [7:0]  wdata_d;
	logic [7:0]  rdata_q;
	logic [7:0]  rdata_d;
	logic        rd_req;
	logic        wr_req;

	// Illegal mode code falls back to the variant without wait
	always_comb begin
		unique case (BUS_MODE)
			2'h0:    mode = lhp_pkg::LHP_GEN_WAIT;
			2'h2:    mode = lhp_pkg::LHP_M68;
			default: mode = lhp_pkg::LHP_GEN_NOWAIT;
		endcase
	end

	assign m68       = (mode == lhp_pkg::LHP_M68);
	assign dstb_n    = m68 ? RD_N : (RD_N & WR_N);
	assign dstb_rise = dstb_n && !dstb_prev_q;
	assign as_rise   = ADDR_STROBE_N && !as_prev_q;
	assign rd_rise   = RD_N && !rd_prev_q;
	// Host keeps its strobe spacing, so a new start only comes from idle
	assign start     = !CS_N && (state_q == lhp_pkg::LHP_IDLE)
		&& (m68 ? (!ADDR_STROBE_N && as_prev_q) : (!dstb_n && dstb_prev_q));
	assign rd_req    = (state_q == lhp_pkg::LHP_BUSY) && !we_q && !sent_q;
	assign wr_req    = pend_q && dstb_rise;

	lhp_wait_timer u_timer (
		.clk     (MCLK),
		.rst     (RST),
		.run     (state_q == lhp_pkg::LHP_BUSY),
		.expired (expired)
	);

	always_comb begin
		state_d = state_q;
		we_d    = we_q;
		sent_d  = sent_q;
		pend_d  = pend_q;
		vld_d   = vld_q;
		addr_d  = addr_q;
		rdata_d = rdata_q;
		unique case (state_q)
			lhp_pkg::LHP_IDLE: begin
				if (start) begin
					state_d = lhp_pkg::LHP_BUSY;
					we_d    = m68 ? !WR_N : !WR_N && RD_N;
					pend_d  = m68 ? !WR_N : !WR_N && RD_N;
					sent_d  = 1'b0;
					vld_d   = 1'b0;
					addr_d  = HOST_ADDR;
				end
			end
			lhp_pkg::LHP_BUSY: begin
				sent_d = 1'b1;
				if (!we_q && CORE_ACK) begin
					rdata_d = CORE_RDATA;
				end
				// Timeout releases wait even when the core is late
				if (we_q || CORE_ACK || expired) begin
					state_d = lhp_pkg::LHP_DONE;
					vld_d   = 1'b1;
				end
			end
			lhp_pkg::LHP_DONE: begin
				if (!m68) begin
					if (dstb_n) begin
						state_d = lhp_pkg::LHP_IDLE;
					end
				end else if (DIRECT_MODE && psave_q) begin
					if (rd_rise) begin
						state_d = lhp_pkg::LHP_IDLE;
					end
				end else if (as_rise) begin
					state_d = lhp_pkg::LHP_TAIL;
				end
			end
			lhp_pkg::LHP_TAIL: begin
				state_d = lhp_pkg::LHP_IDLE;
			end
		endcase
		if (wr_req) begin
			pend_d = 1'b0;
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			state_q <= lhp_pkg::LHP_IDLE;
			we_q    <= 1'b0;
			sent_q  <= 1'b0;
			pend_q  <= 1'b0;
			vld_q   <= 1'b0;
			addr_q  <= '0;
			rdata_q <= '0;
		end else begin
			state_q <= state_d;
			we_q    <= we_d;
			sent_q  <= sent_d;
			pend_q  <= pend_d;
			vld_q   <= vld_d;
			addr_q  <= addr_d;
			rdata_q <= rdata_d;
		end
	end

	// Strobe history, write data and the power save bit
	always_comb begin
		wdata_d = dstb_n ? wdata_q : HOST_DATA_I;
		psave_d = psave_q;
		if (wr_req && addr_q == `LHP_PSAVE_ADDR) begin
			psave_d = wdata_q[`LHP_PSAVE_BIT];
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			dstb_prev_q <= 1'b1;
			as_prev_q   <= 1'b1;
			rd_prev_q   <= 1'b1;
			wdata_q     <= '0;
			psave_q     <= `LHP_PSAVE_RST;
		end else begin
			dstb_prev_q <= dstb_n;
			as_prev_q   <= ADDR_STROBE_N;
			rd_prev_q   <= RD_N;
			wdata_q     <= wdata_d;
			psave_q     <= psave_d;
		end
	end

	// Write goes to the core only once data has settled at strobe rise
	assign CORE_REQ     = rd_req || wr_req;
	assign CORE_WE      = wr_req;
	assign CORE_ADDR    = addr_q;
	assign CORE_WDATA   = wdata_q;
	assign POWER_SAVE   = psave_q;
	assign HOST_DATA_O  = rdata_q;
	assign HOST_DATA_OE = !CS_N && !RD_N && (m68 ? WR_N : 1'b1);

	// Generic with wait: low while busy; strobed: high while busy, low as acknowledge
	always_comb begin
		XFER_ACK_N_OE = 1'b0;
		XFER_ACK_N_O  = 1'b1;
		if (mode == lhp_pkg::LHP_GEN_WAIT) begin
			XFER_ACK_N_OE = (state_q == lhp_pkg::LHP_BUSY) || (state_q == lhp_pkg::LHP_DONE);
			XFER_ACK_N_O  = (state_q != lhp_pkg::LHP_BUSY);
		end else if (m68) begin
			XFER_ACK_N_OE = (state_q != lhp_pkg::LHP_IDLE);
			XFER_ACK_N_O  = (state_q != lhp_pkg::LHP_DONE);
		end
	end

	logic [2:0] wl_cnt_q;
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			wl_cnt_q <= '0;
		end else if (XFER_ACK_N_OE && !XFER_ACK_N_O && !m68) begin
			wl_cnt_q <= (wl_cnt_q == 3'h7) ? wl_cnt_q : wl_cnt_q + 3'h1;
		end else begin
			wl_cnt_q <= '0;
		end
	end

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RST);

	sequence s_busy_ends;
		##[1:4] (state_q == lhp_pkg::LHP_DONE);
	endsequence

	property p_wait_low_on_fall;
		(start && mode == lhp_pkg::LHP_GEN_WAIT) |=> XFER_ACK_N_OE && !XFER_ACK_N_O;
	endproperty
	a_wait_low_on_fall: assert property (p_wait_low_on_fall) else $error("wait not low after strobe");

	property p_wait_float;
		(!m68 && state_q == lhp_pkg::LHP_DONE && dstb_n) |=> !XFER_ACK_N_OE;
	endproperty
	a_wait_float: assert property (p_wait_float) else $error("wait not floated after strobe rise");

	property p_wait_max;
		wl_cnt_q <= 3'(`LHP_WAIT_MAX_CYC);
	endproperty
	a_wait_max: assert property (p_wait_max) else $error("wait held too long");

	property p_read_data;
		(state_q == lhp_pkg::LHP_BUSY && !we_q && CORE_ACK)
			|=> (HOST_DATA_O == $past(CORE_RDATA)) && (m68 ? !XFER_ACK_N_O : XFER_ACK_N_O);
	endproperty
	a_read_data: assert property (p_read_data) else $error("read data not loaded at release");

	property p_nowait_data;
		(start && !we_d) |-> ##[1:5] vld_q;
	endproperty
	a_nowait_data: assert property (p_nowait_data) else $error("read data late");

	property p_ack_drive;
		(start && m68) |=> XFER_ACK_N_OE && XFER_ACK_N_O;
	endproperty
	a_ack_drive: assert property (p_ack_drive) else $error("ack line not driven");

	property p_psave_float;
		(m68 && DIRECT_MODE && psave_q && state_q == lhp_pkg::LHP_DONE && rd_rise)
			|=> !XFER_ACK_N_OE;
	endproperty
	a_psave_float: assert property (p_psave_float) else $error("wait not floated on read rise");

	property p_as_release;
		(m68 && !(DIRECT_MODE && psave_q) && state_q == lhp_pkg::LHP_DONE && as_rise)
			|=> XFER_ACK_N_OE && XFER_ACK_N_O ##1 !XFER_ACK_N_OE;
	endproperty
	a_as_release: assert property (p_as_release) else $error("ack not released in time");

	property p_ack_bound;
		(start && m68) |=> s_busy_ends;
	endproperty
	a_ack_bound: assert property (p_ack_bound) else $error("ack inactive too long");

	property p_psave_write;
		(wr_req && addr_q == `LHP_PSAVE_ADDR) |=> POWER_SAVE == $past(wdata_q[`LHP_PSAVE_BIT]);
	endproperty
	a_psave_write: assert property (p_psave_write) else $error("power save bit not updated");
endmodule

// *** lhp_host_model.sv ***
// Host bus master model driving the port's strobes, address and data
`timescale 1ns/1ps
module lhp_host_model (
	input  wire logic        MCLK,
	output logic             CS_N,
	output logic      [15:0] HOST_ADDR,
	output logic      [7:0]  HOST_DATA_I,
	output logic             RD_N,
	output logic             WR_N,
	output logic             ADDR_STROBE_N
);
	initial begin
		CS_N = 1'b1;
		HOST_ADDR = 16'h0000;
		HOST_DATA_I = 8'h00;
		RD_N = 1'b1;
		WR_N = 1'b1;
		ADDR_STROBE_N = 1'b1;
	end

	// Strobed bus: RD_N is the data strobe, WR_N the read/write line
	task automatic access(input logic [1:0] m, input logic we, input logic [15:0] a,
		input logic [7:0] d);
		@(negedge MCLK);
		CS_N = 1'b0;
		HOST_ADDR = a;
		HOST_DATA_I = we ? d : ~d;
		WR_N = !we;
		RD_N = (m != 2'h2) && we;
		ADDR_STROBE_N = (m != 2'h2);
		repeat (5) @(negedge MCLK);
		RD_N = 1'b1;
		if (m != 2'h2) begin
			WR_N = 1'b1;
		end
		repeat (2) @(negedge MCLK);
		// Released address shows the inverse, never the last value; read data stays at ~d
		ADDR_STROBE_N = 1'b1;
		WR_N = 1'b1;
		HOST_DATA_I = ~d;
		HOST_ADDR = ~a;
		CS_N = 1'b1;
		repeat (we ? 4 : 3) @(negedge MCLK);
	endtask
endmodule

// *** lhp_tb.sv ***
// Self-checking bench for the host bus port
`timescale 1ns/1ps
module tb;
	logic        MCLK, RST, DIRECT_MODE, CORE_ACK;
	logic [1:0]  BUS_MODE;
	logic [7:0]  CORE_RDATA, HOST_DATA_O, HOST_DATA_I, CORE_WDATA;
	logic [15:0] HOST_ADDR, CORE_ADDR;
	wire         CS_N, RD_N, WR_N, ADDR_STROBE_N;
	logic        HOST_DATA_OE, XFER_ACK_N_O, XFER_ACK_N_OE, CORE_REQ, CORE_WE, POWER_SAVE;
	logic [24:0] q[$];
	logic [7:0]  rq[$];
	logic        ps_exp, s, rel;
	int          error_cnt, cmp_count, rc, sc, ac, lo, hi;

	lhp_host_model host (.MCLK(MCLK), .CS_N(CS_N), .HOST_ADDR(HOST_ADDR),
		.HOST_DATA_I(HOST_DATA_I), .RD_N(RD_N), .WR_N(WR_N), .ADDR_STROBE_N(ADDR_STROBE_N));
	lhp_host_port DUT (.MCLK(MCLK), .RST(RST), .BUS_MODE(BUS_MODE), .DIRECT_MODE(DIRECT_MODE),
		.CS_N(CS_N), .HOST_ADDR(HOST_ADDR), .HOST_DATA_I(HOST_DATA_I),
		.HOST_DATA_O(HOST_DATA_O), .HOST_DATA_OE(HOST_DATA_OE), .RD_N(RD_N), .WR_N(WR_N),
		.ADDR_STROBE_N(ADDR_STROBE_N), .XFER_ACK_N_O(XFER_ACK_N_O),
		.XFER_ACK_N_OE(XFER_ACK_N_OE), .CORE_REQ(CORE_REQ), .CORE_WE(CORE_WE),
		.CORE_ADDR(CORE_ADDR), .CORE_WDATA(CORE_WDATA), .CORE_ACK(CORE_ACK),
		.CORE_RDATA(CORE_RDATA), .POWER_SAVE(POWER_SAVE));

	always #5 MCLK = ~MCLK;

	task automatic ck(input logic [24:0] got, input logic [24:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask

	task automatic wrap_up;
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic acc(input logic [1:0] m, input logic we, input logic [15:0] a,
		input logic [7:0] d);
		@(negedge MCLK);
		BUS_MODE = m;
		q.push_back({we, a, we ? d : 8'h00});
		host.access(m, we, a, d);
		if (we && a == 16'h0008) ps_exp = d[0];
	endtask

	// Core side: read answers arrive zero to two cycles late
	always @(negedge MCLK) begin
		if (CORE_REQ === 1'b1 && CORE_WE === 1'b0) begin
			repeat ($urandom_range(2)) @(negedge MCLK);
			CORE_ACK = 1'b1;
			CORE_RDATA = 8'($urandom);
			rq.push_back(CORE_RDATA);
			@(negedge MCLK);
			CORE_ACK = 1'b0;
			CORE_RDATA = ~CORE_RDATA;
		end
	end

	// Core requests against the notes left by the driver
	// Write requests stand from strobe rise to the next edge, so look just after it
	always @(negedge MCLK) begin
		#1;
		if (CORE_REQ === 1'b1) begin
			if (q.size() == 0) ck(25'h1, 25'h0);
			else ck({CORE_WE, CORE_ADDR, CORE_WE ? CORE_WDATA : 8'h00}, q.pop_front());
		end
	end

	// Wait line timing, counted after each edge has settled
	always @(posedge MCLK) begin
		#1;
		s = (BUS_MODE == 2'h2) ? RD_N : (RD_N & WR_N);
		rel = DIRECT_MODE && ps_exp;
		rc = s ? rc + 1 : 0;
		sc = s ? 0 : sc + 1;
		ac = ADDR_STROBE_N ? ac + 1 : 0;
		lo = (XFER_ACK_N_OE && !XFER_ACK_N_O) ? lo + 1 : 0;
		hi = (XFER_ACK_N_OE && XFER_ACK_N_O) ? hi + 1 : 0;
		if (!RST) begin
			if (sc == 5 && WR_N) begin
				if (rq.size() == 0) ck(25'h1, 25'h0);
				else ck(25'(HOST_DATA_O), 25'(rq.pop_front()));
			end
			if (sc == 5) ck(25'(HOST_DATA_OE), 25'(WR_N));
			case (BUS_MODE)
				2'h0: begin
					if (sc == 1) ck(25'(lo), 25'h1);
					if (rc == 2) ck(25'(XFER_ACK_N_OE), 25'h0);
					if (lo > 4) ck(25'(lo), 25'h4);
				end
				2'h2: begin
					if (sc == 1) ck(25'({XFER_ACK_N_OE, XFER_ACK_N_O}), 25'h3);
					if (hi > 4) ck(25'(hi), 25'h4);
					if (rel && rc == 2) ck(25'(XFER_ACK_N_OE), 25'h0);
					if (!rel && ac == 1) ck(25'({XFER_ACK_N_OE, XFER_ACK_N_O}), 25'h3);
					if (!rel && ac == 2) ck(25'(XFER_ACK_N_OE), 25'h0);
				end
				default: ck(25'(XFER_ACK_N_OE), 25'h0);
			endcase
		end
	end

	// Hang guard
	initial begin
		repeat (5000) @(posedge MCLK);
		error_cnt++;
		wrap_up();
	end

	initial begin
		MCLK = 1'b0;
		RST = 1'b1;
		BUS_MODE = 2'h0;
		DIRECT_MODE = 1'b0;
		CORE_ACK = 1'b0;
		CORE_RDATA = 8'h00;
		ps_exp = 1'b0;
		void'($urandom(32'h8c6cf184));
		repeat (4) @(posedge MCLK);
		@(negedge MCLK);
		RST = 1'b0;
		ck(25'(POWER_SAVE), 25'h0);
		for (int i = 0; i < 24; i++) begin
			DIRECT_MODE = 1'($urandom);
			acc(2'(i / 6), 1'($urandom), 16'($urandom) | 16'h0010, 8'($urandom));
		end
		acc(2'h0, 1'b1, 16'h0008, 8'h35);
		ck(25'(POWER_SAVE), 25'h1);
		// Direct interface in power save floats on the data strobe
		DIRECT_MODE = 1'b1;
		repeat (4) acc(2'h2, 1'($urandom), 16'h0123, 8'($urandom));
		acc(2'h0, 1'b1, 16'h0008, 8'hc2);
		ck(25'(POWER_SAVE), 25'h0);
		acc(2'h2, 1'b0, 16'h0456, 8'h00);
		repeat (5) @(negedge MCLK);
		ck(25'(q.size() + rq.size()), 25'h0);
		wrap_up();
	end
endmodule
